// ==== design/cpd_pkg.sv ====
package cpd_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int PWM_HZ = 4_000;
  localparam int GRAY_W = 8;
  localparam int BRIGHT_W = 5;
  localparam int FRAME_BITS = 32;
  localparam int START_LEN = 32;
  localparam int FIFO_DEPTH = 32;
  localparam int PWM_STEPS = 256;
  localparam int BRIGHT_MAX = 31;
  // longest step time rounds down, never below one cycle
  localparam int PWM_STEP_RAW = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int PWM_STEP_CYCLES = (PWM_STEP_RAW < 1) ? 1 : PWM_STEP_RAW;

  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COLOUR = 4'h8;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int STAT_OVF_BIT = 0;
  localparam int STAT_STATE_LSB = 1;
  localparam int STAT_LEVEL_LSB = 8;
  localparam logic [31:0] RESET_COLOUR = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] marker;
    logic [BRIGHT_W-1:0] bright;
    logic [GRAY_W-1:0] blue;
    logic [GRAY_W-1:0] green;
    logic [GRAY_W-1:0] red;
  } cpd_pixel_t;

  typedef struct packed {
    logic [GRAY_W-1:0] step;
    logic [BRIGHT_W-1:0] bright_slot;
  } cpd_timebase_t;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_FORWARD = 2'b10
  } cpd_state_t;
endpackage : cpd_pkg

// ==== design/cpd_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= level + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_level: assert property (@(posedge clk) disable iff (!arst_n)
    push && !pop |=> level == $past(level) + 1'b1)
    else $error("fifo level did not count a push");
endmodule : cpd_fifo
`default_nettype wire

// ==== design/cpd_pwm_channel.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpd_pwm_channel #(
  parameter int GW = 8,
  parameter int BW = 5
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [GW-1:0] step,
  input wire logic [BW-1:0] bright_slot,
  input wire logic [GW-1:0] gray,
  input wire logic [BW-1:0] bright,
  output logic pwm
);
  // gray sets on-time within a period, brightness sets the share of periods that light
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (step < gray) && (bright_slot < bright);
    end
  end

  a_gray_zero_off: assert property (@(posedge clk) disable iff (!arst_n)
    gray == '0 |=> !pwm)
    else $error("channel lit with zero gray");
  a_bright_zero_off: assert property (@(posedge clk) disable iff (!arst_n)
    bright == '0 |=> !pwm)
    else $error("channel lit with zero brightness");
  a_full_gray_on: assert property (@(posedge clk) disable iff (!arst_n)
    gray == '1 && bright == '1 && step != '1 |=> pwm)
    else $error("full gray and brightness left channel dark");
endmodule : cpd_pwm_channel
`default_nettype wire

// ==== design/cpd_pixel_driver.sv ====
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - serial_in is sampled on each settled rising shift_clock_in edge.
// - serial_out changes right after a rising shift_clock_in edge.
// - a bit leaves on serial_out only after it was sampled in.
// - each rising edge samples one bit in and drives one bit out together.
// - shift_clock_out is the input clock shifted by half a period.
// - red, green and blue each take an 8-bit gray value.
// - gray n gives duty n/256 per channel.
// - one 5-bit brightness scales all three channels together.
// - serial input up to 30 MHz; this core tracks about clk/6.
// - PWM period runs near 4 kHz from the local clock, not the link.
// - latched colour keeps driving PWM after traffic stops.
// - brightness code k gives k/31 of full output.
module cpd_pixel_driver #(
  parameter int FIFO_DEPTH = cpd_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic serial_in,
  input wire logic shift_clock_in,
  output logic serial_out,
  output logic shift_clock_out,
  output logic pwm_red,
  output logic pwm_green,
  output logic pwm_blue,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam int PW = $clog2(cpd_pkg::PWM_STEP_CYCLES + 1);

  logic [2:0] ck_sync;
  logic [2:0] sd_sync;
  logic ck_level;
  logic sd_level;
  logic rise;
  cpd_pkg::cpd_state_t state;
  logic [5:0] zero_run;
  logic start_seen;
  logic [4:0] bit_cnt;
  logic [31:0] shreg;
  logic push_valid;
  cpd_pkg::cpd_pixel_t push_data;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  cpd_pkg::cpd_pixel_t fifo_out_data;
  logic [LW-1:0] fifo_level;
  cpd_pkg::cpd_pixel_t colour;
  logic [PW-1:0] presc;
  logic step_tick;
  cpd_pkg::cpd_timebase_t tb;
  logic period_end;
  logic ctrl_hold;
  logic overflow;
  logic bus_req;
  logic bus_go;

  // three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_sync <= 3'h0;
      sd_sync <= 3'h0;
      ck_level <= 1'b0;
      sd_level <= 1'b0;
    end else begin
      ck_sync <= {ck_sync[1:0], shift_clock_in};
      sd_sync <= {sd_sync[1:0], serial_in};
      if (ck_sync[1] == ck_sync[2]) begin
        ck_level <= ck_sync[2];
      end
      if (sd_sync[1] == sd_sync[2]) begin
        sd_level <= sd_sync[2];
      end
    end
  end

  // data was launched on the falling edge, so it has long settled at the rise
  assign rise = (ck_sync[1] == ck_sync[2]) && ck_sync[2] && !ck_level;
  assign start_seen = !sd_level && (zero_run >= 6'(cpd_pkg::START_LEN - 1));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      zero_run <= 6'h00;
    end else if (rise) begin
      if (sd_level) begin
        zero_run <= 6'h00;
      end else if (zero_run < 6'(cpd_pkg::START_LEN)) begin
        zero_run <= zero_run + 6'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= cpd_pkg::ST_HUNT;
      bit_cnt <= 5'h00;
      shreg <= 32'h0000_0000;
    end else if (rise) begin
      case (state)
        cpd_pkg::ST_HUNT: begin
          if (start_seen) begin
            state <= cpd_pkg::ST_CAPTURE;
            bit_cnt <= 5'h00;
          end
        end
        cpd_pkg::ST_CAPTURE: begin
          // leading zeros past the start frame are not yet the pixel frame
          if (bit_cnt != 5'h00 || sd_level) begin
            shreg <= {shreg[30:0], sd_level};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(cpd_pkg::FRAME_BITS - 1)) begin
              state <= cpd_pkg::ST_FORWARD;
            end
          end
        end
        cpd_pkg::ST_FORWARD: begin
          if (start_seen) begin
            state <= cpd_pkg::ST_CAPTURE;
            bit_cnt <= 5'h00;
          end
        end
        default: begin
          state <= cpd_pkg::ST_HUNT;
        end
      endcase
    end
  end

  // own frame is swallowed: downstream sees zeros, which only lengthen its start frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      serial_out <= 1'b0;
    end else if (rise) begin
      serial_out <= (state == cpd_pkg::ST_CAPTURE) ? 1'b0 : sd_level;
    end
  end

  // inverted copy of the settled input clock, half a period away from it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_clock_out <= 1'b1;
    end else begin
      shift_clock_out <= !ck_level;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      push_valid <= 1'b0;
      push_data <= cpd_pkg::cpd_pixel_t'(cpd_pkg::RESET_COLOUR);
    end else begin
      push_valid <= rise && (state == cpd_pkg::ST_CAPTURE)
        && (bit_cnt == 5'(cpd_pkg::FRAME_BITS - 1));
      push_data <= cpd_pkg::cpd_pixel_t'({shreg[30:0], sd_level});
    end
  end

  cpd_fifo #(
    .WIDTH($bits(cpd_pkg::cpd_pixel_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );

  // new colour only at a period boundary, so no period shows a torn value
  assign fifo_pop = fifo_out_valid && period_end && !ctrl_hold;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      colour <= cpd_pkg::cpd_pixel_t'(cpd_pkg::RESET_COLOUR);
    end else if (fifo_pop) begin
      colour <= fifo_out_data;
    end
  end

  // local timebase, free of the link clock
  assign step_tick = (presc == PW'(cpd_pkg::PWM_STEP_CYCLES - 1));
  assign period_end = step_tick && (tb.step == '1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc <= '0;
      tb <= '0;
    end else begin
      presc <= step_tick ? '0 : presc + 1'b1;
      if (step_tick) begin
        tb.step <= tb.step + 8'h01;
      end
      if (period_end) begin
        tb.bright_slot <= (tb.bright_slot == 5'(cpd_pkg::BRIGHT_MAX - 1)) ? 5'h00
          : tb.bright_slot + 5'h01;
      end
    end
  end

  cpd_pwm_channel #(.GW(cpd_pkg::GRAY_W), .BW(cpd_pkg::BRIGHT_W)) u_red (
    .clk(clk), .arst_n(arst_n), .step(tb.step), .bright_slot(tb.bright_slot),
    .gray(colour.red), .bright(colour.bright), .pwm(pwm_red)
  );
  cpd_pwm_channel #(.GW(cpd_pkg::GRAY_W), .BW(cpd_pkg::BRIGHT_W)) u_green (
    .clk(clk), .arst_n(arst_n), .step(tb.step), .bright_slot(tb.bright_slot),
    .gray(colour.green), .bright(colour.bright), .pwm(pwm_green)
  );
  cpd_pwm_channel #(.GW(cpd_pkg::GRAY_W), .BW(cpd_pkg::BRIGHT_W)) u_blue (
    .clk(clk), .arst_n(arst_n), .step(tb.step), .bright_slot(tb.bright_slot),
    .gray(colour.blue), .bright(colour.bright), .pwm(pwm_blue)
  );

  // avalon slave: one wait cycle, then the access completes
  assign bus_req = avs_read || avs_write;
  assign bus_go = bus_req && !avs_waitrequest;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest) begin
        case (avs_address)
          cpd_pkg::REG_CTRL: avs_readdata <= {31'h0, ctrl_hold};
          cpd_pkg::REG_STATUS: avs_readdata <= {16'h0, 8'(fifo_level), 5'h0, state, overflow};
          cpd_pkg::REG_COLOUR: avs_readdata <= colour;
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_hold <= 1'b0;
    end else if (bus_go && avs_write && avs_address == cpd_pkg::REG_CTRL) begin
      ctrl_hold <= avs_writedata[cpd_pkg::CTRL_HOLD_BIT];
    end
  end

  // a frame lost to a full buffer sets this; a new loss wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow <= 1'b0;
    end else if (push_valid && !fifo_in_ready) begin
      overflow <= 1'b1;
    end else if (bus_go && avs_write && avs_address == cpd_pkg::REG_STATUS
                 && avs_writedata[cpd_pkg::STAT_OVF_BIT]) begin
      overflow <= 1'b0;
    end
  end

  sequence s_bus_wait;
    bus_req && avs_waitrequest;
  endsequence
  sequence s_bus_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  a_bus_answer: assert property (@(posedge clk) disable iff (!arst_n)
    s_bus_wait |=> s_bus_done)
    else $error("bus access not answered after one wait cycle");
  a_sample_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(shreg) |-> $past(rise))
    else $error("input shifted without a rising link clock");
  a_out_on_rise: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(serial_out) |-> $past(rise))
    else $error("serial_out moved without a rising link clock");
  a_forward_bit: assert property (@(posedge clk) disable iff (!arst_n)
    rise && state == cpd_pkg::ST_FORWARD |=> serial_out == $past(sd_level))
    else $error("forwarded bit differs from sampled bit");
  a_clock_half: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(ck_level) |=> !shift_clock_out ##0 $past(shift_clock_out))
    else $error("clock out not opposite to clock in");
  a_start_detect: assert property (@(posedge clk) disable iff (!arst_n)
    rise && start_seen && state != cpd_pkg::ST_CAPTURE |=> state == cpd_pkg::ST_CAPTURE)
    else $error("start frame not recognised");
  a_frame_capture: assert property (@(posedge clk) disable iff (!arst_n)
    rise && state == cpd_pkg::ST_CAPTURE && bit_cnt == 5'h1f
    |=> push_valid && state == cpd_pkg::ST_FORWARD)
    else $error("pixel frame not kept after 32 bits");
  a_colour_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !fifo_pop |=> $stable(colour))
    else $error("colour changed without a buffer pop");
  a_step_period: assert property (@(posedge clk) disable iff (!arst_n)
    step_tick |=> presc == '0 ##1 !step_tick)
    else $error("pwm step timebase out of order");
endmodule : cpd_pixel_driver
`default_nettype wire

// ==== test/cpd_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module cpd_host_model (
  output logic shift_clock,
  output logic serial
);
  localparam int HALF_NS = 200;
  // the link clock stands low between updates
  initial begin
    shift_clock = 1'b0;
    serial = 1'b0;
  end
  // msb first, data moves only while the clock is low
  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serial = w[i];
      #HALF_NS shift_clock = 1'b1;
      #HALF_NS shift_clock = 1'b0;
    end
  endtask : send_word
  task automatic send_update(input logic [31:0] px[$]);
    send_word(32'h0000_0000);
    foreach (px[i]) send_word(px[i]);
    send_word(32'hffff_ffff);
    // released line shows the inverse of the last bit, never a stale copy
    serial = 1'b0;
  endtask : send_update
endmodule : cpd_host_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  // small buffer so that filling and draining fit the run
  localparam int DEPTH = 4;
  localparam int PERIOD = cpd_pkg::PWM_STEPS * cpd_pkg::PWM_STEP_CYCLES;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sck, sdat, serial_out, shift_clock_out, pwm_red, pwm_green, pwm_blue;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  int n_errors = 0;
  int n_compared = 0;
  logic [31:0] rs = 32'hec3094fa;
  logic [31:0] rd;
  logic din[$];
  cpd_pkg::cpd_pixel_t f0, lastf;

  always #25 clk = ~clk;

  cpd_host_model host (.shift_clock(sck), .serial(sdat));
  cpd_pixel_driver #(.FIFO_DEPTH(DEPTH)) uut (.clk(clk), .arst_n(arst_n), .serial_in(sdat),
    .shift_clock_in(sck), .serial_out(serial_out), .shift_clock_out(shift_clock_out),
    .pwm_red(pwm_red), .pwm_green(pwm_green), .pwm_blue(pwm_blue),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task end_sim;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic av(input logic we, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= we;
    avs_read <= ~we;
    // only the watchdog ends a wait that never gets its answer
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av

  // the bit taken at one rise must stand on serial_out at the next rise; own-frame bits must read zero
  always @(posedge sck) begin
    if (din.size() >= 33)
      chk("serial_out", (din.size() <= 64) ? 32'h0 : {31'h0, din[din.size()-1]},
          {31'h0, serial_out});
    din.push_back(sdat);
  end
  always @(posedge sck) begin
    #300 chk("shift_clock_out low", 32'h0, {31'h0, shift_clock_out});
  end
  always @(negedge sck) begin
    #300 chk("shift_clock_out high", 32'h1, {31'h0, shift_clock_out});
  end

  task automatic update(input logic [31:0] own, input logic [31:0] fwd);
    logic [31:0] q[$];
    q = '{own, fwd};
    din.delete();
    @(posedge clk);
    #13 host.send_update(q);
  endtask : update

  task automatic wait_colour(input logic [31:0] exp, input int lim);
    int n;
    n = 0;
    do begin
      av(1'b0, cpd_pkg::REG_COLOUR, 32'h0, rd);
      n++;
    end while (rd !== exp && n < lim);
    chk("colour", exp, rd);
  endtask : wait_colour

  // one full period after traffic stopped; only full or zero brightness used
  task automatic measure(input cpd_pkg::cpd_pixel_t f);
    int cr, cg, cb, k;
    cr = 0;
    cg = 0;
    cb = 0;
    k = (f.bright == cpd_pkg::BRIGHT_MAX) ? cpd_pkg::PWM_STEP_CYCLES : 0;
    repeat (PERIOD) begin
      @(posedge clk);
      cr += (pwm_red === 1'b1);
      cg += (pwm_green === 1'b1);
      cb += (pwm_blue === 1'b1);
    end
    chk("pwm_red", 32'(f.red * k), 32'(cr));
    chk("pwm_green", 32'(f.green * k), 32'(cg));
    chk("pwm_blue", 32'(f.blue * k), 32'(cb));
  endtask : measure

  initial begin
    #5_000_000;
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    av(1'b0, cpd_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl", 32'h0, rd);
    av(1'b0, cpd_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 32'h0, rd);
    av(1'b0, cpd_pkg::REG_COLOUR, 32'h0, rd);
    chk("colour", cpd_pkg::RESET_COLOUR, rd);
    av(1'b1, 4'hc, 32'hffff_ffff, rd);
    av(1'b0, 4'hc, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    rs = lfsr(rs);
    f0 = {3'b111, 5'd31, rs[7:0], 8'h00, 8'hff};
    rs = lfsr(rs);
    update(f0, rs);
    wait_colour(f0, 3000);
    measure(f0);
    rs = lfsr(rs);
    f0 = {3'b111, 5'd0, 8'hff, 8'hff, rs[7:0]};
    update(f0, ~rs);
    wait_colour(f0, 3000);
    measure(f0);
    // hold loading so the buffer overflows by one frame
    av(1'b1, cpd_pkg::REG_CTRL, 32'h1, rd);
    av(1'b0, cpd_pkg::REG_CTRL, 32'h0, rd);
    chk("ctrl", 32'h1, rd);
    for (int i = 0; i <= DEPTH; i++) begin
      rs = lfsr(rs);
      f0 = {3'b111, 5'd31, rs[23:0]};
      if (i < DEPTH) lastf = f0;
      update(f0, ~rs);
    end
    av(1'b0, cpd_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 32'(DEPTH << 8) | 32'h1, rd & 32'h0000_ff01);
    av(1'b1, cpd_pkg::REG_STATUS, 32'h1, rd);
    av(1'b0, cpd_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 32'(DEPTH << 8), rd & 32'h0000_ff01);
    av(1'b1, cpd_pkg::REG_CTRL, 32'h0, rd);
    wait_colour(lastf, 10000);
    av(1'b0, cpd_pkg::REG_STATUS, 32'h0, rd);
    chk("status", 32'h0, rd & 32'h0000_ff01);
    measure(lastf);
    end_sim();
  end
endmodule : tb
`default_nettype wire
